// [design/wt_timer_regs.sv]
// Register file and control core of the 12-bit waveform timer
//
// The plain strobed port was left to the implementer.
module wt_timer_regs
    import wt_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [DATA_W-1:0] rdata,
    // Timer clock sources
    input wire logic fast_osc_tick,
    input wire logic ext_clock_pin,
    // Waveforms, events and interrupt
    output logic wave_a,
    output logic wave_b,
    output logic match_a_set_evt,
    output logic match_b_set_evt,
    output logic match_b_clear_evt,
    output logic irq
);
    // ==========================================================
    // Storage
    logic [7:0] regs_q [0:MAP_SIZE-1];
    logic mc_en_r;
    logic [1:0] clk_sel_r;
    logic [1:0] cpres_r;
    logic [1:0] spres_r;
    logic running_r;
    logic en_pend_r;
    logic [1:0] en_cnt_r;
    logic stop_pend_r;
    logic [4:0] cmd_pend_r;
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] cap_a_r;
    logic [CNT_W-1:0] cap_b_r;
    logic [4:0] cdiv_r;
    logic [2:0] sdiv_r;
    logic ext_s1_r;
    logic ext_s2_r;
    logic ext_s3_r;
    logic [7:0] rdata_r;
    logic wave_a_r;
    logic wave_b_r;
    logic evt_a_r;
    logic evt_b_r;
    logic evt_c_r;

    // ==========================================================
    // Decode
    wire wr_main = wr_stb && addr == OFS_MAIN_CONTROL;
    wire wr_cmd = wr_stb && addr == OFS_COMMAND_STROBES;
    wire rd_flags = rd_stb && addr == OFS_INTERRUPT_FLAGS;
    wire in_map = addr < ADDR_W'(MAP_SIZE);
    wire [CNT_W-1:0] cmp_a_set =
        {regs_q[OFS_COMPARE_A_SET + 1][3:0], regs_q[OFS_COMPARE_A_SET]};
    wire [CNT_W-1:0] cmp_a_clr =
        {regs_q[OFS_COMPARE_A_CLEAR + 1][3:0], regs_q[OFS_COMPARE_A_CLEAR]};
    wire [CNT_W-1:0] cmp_b_set =
        {regs_q[OFS_COMPARE_B_SET + 1][3:0], regs_q[OFS_COMPARE_B_SET]};
    wire [CNT_W-1:0] cmp_b_clr =
        {regs_q[OFS_COMPARE_B_CLEAR + 1][3:0], regs_q[OFS_COMPARE_B_CLEAR]};

    // ==========================================================
    // Timer tick selection
    wire ext_edge = ext_s2_r && !ext_s3_r;
    wire timer_tick =
        (clk_sel_r == CLK_FAST_OSC) ? fast_osc_tick :
        (clk_sel_r == CLK_EXTERNAL) ? ext_edge :
        (clk_sel_r == CLK_SYSTEM);
    wire [4:0] cdiv_last =
        (cpres_r == CPRES_DIV4) ? DIV4_LAST :
        (cpres_r == CPRES_DIV32) ? DIV32_LAST : 5'h00;
    wire [2:0] sdiv_last =
        (spres_r == 2'h0) ? SYNC_DIV_LAST_1 :
        (spres_r == 2'h1) ? SYNC_DIV_LAST_2 :
        (spres_r == 2'h2) ? SYNC_DIV_LAST_4 : SYNC_DIV_LAST_8;
    wire cnt_tick = timer_tick && cdiv_r == cdiv_last;
    wire sync_tick = timer_tick && sdiv_r == sdiv_last;
    wire [4:0] cdiv_nxt = (cdiv_r >= cdiv_last) ? 5'h00 : cdiv_r + 5'h01;
    wire [2:0] sdiv_nxt = (sdiv_r >= sdiv_last) ? 3'h0 : sdiv_r + 3'h1;

    // ==========================================================
    // Counter events
    wire cycle_end = running_r && cnt_tick && count_r == cmp_b_clr;
    wire hit_a = running_r && cnt_tick && count_r == cmp_a_set;
    wire hit_b = running_r && cnt_tick && count_r == cmp_b_set;
    wire clr_a = running_r && cnt_tick && count_r == cmp_a_clr;
    wire restart_go = cmd_pend_r[CS_RESTART_BIT] && sync_tick;
    wire en_busy = en_pend_r || stop_pend_r;
    wire en_write_ok = wr_main && !en_busy;
    wire field_write_ok = wr_main && !mc_en_r && !running_r;
    wire stop_write_ok =
        wr_cmd && wdata[CS_STOP_BIT] && !en_busy && running_r;
    wire cmd_write_ok = wr_cmd && cmd_pend_r == 5'h00;
    wire en_cross_done =
        en_pend_r && timer_tick && en_cnt_r == EN_SYNC_TICKS - 2'h1;
    wire cmd_go_now = sync_tick;
    wire eoc_go = cmd_pend_r[CS_SYNCEOC_BIT] && cycle_end;
    wire eoc_done = eoc_go || (cmd_pend_r[CS_SYNCEOC_BIT] && !running_r);
    wire cap_a_go = cmd_go_now && cmd_pend_r[CS_CAPA_BIT];
    wire cap_b_go = cmd_go_now && cmd_pend_r[CS_CAPB_BIT];

    // ==========================================================
    // Plain storage bytes
    genvar gi;
    generate
        for (gi = 0; gi < MAP_SIZE; gi++)
        begin : g_byte
            localparam logic [7:0] WM = wt_wmask(gi);
            always_ff @(posedge clock or negedge rst_b)
            begin
                if (!rst_b)
                    regs_q[gi] <= REG_RESET;
                else if (wr_stb && addr == ADDR_W'(gi) && WM != 8'h00)
                    regs_q[gi] <= wdata & WM;
            end
        end
    endgenerate

    // ==========================================================
    // Main control and enable crossing
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mc_en_r <= MAIN_CONTROL_RESET[MC_EN_BIT];
            clk_sel_r <= MAIN_CONTROL_RESET[MC_CLOCK_SOURCE_SEL_LSB +: 2];
            cpres_r <= MAIN_CONTROL_RESET[MC_CPRES_LSB +: 2];
            spres_r <= MAIN_CONTROL_RESET[MC_SPRES_LSB +: 2];
        end
        else
        begin
            if (field_write_ok)
            begin
                clk_sel_r <= wdata[MC_CLOCK_SOURCE_SEL_LSB +: 2];
                cpres_r <= wdata[MC_CPRES_LSB +: 2];
                spres_r <= wdata[MC_SPRES_LSB +: 2];
            end
            if (en_write_ok)
                mc_en_r <= wdata[MC_EN_BIT];
            else if (stop_pend_r && cycle_end)
                mc_en_r <= 1'b0;
        end
    end

    // Crossing waits a fixed count of timer ticks
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            en_pend_r <= 1'b0;
            en_cnt_r <= 2'h0;
            running_r <= 1'b0;
            stop_pend_r <= 1'b0;
        end
        else
        begin
            if (en_write_ok && wdata[MC_EN_BIT] != running_r)
            begin
                en_pend_r <= 1'b1;
                en_cnt_r <= 2'h0;
            end
            else if (en_cross_done)
            begin
                en_pend_r <= 1'b0;
                running_r <= mc_en_r;
            end
            else if (en_pend_r && timer_tick)
                en_cnt_r <= en_cnt_r + 2'h1;
            if (stop_write_ok)
                stop_pend_r <= 1'b1;
            else if (stop_pend_r && cycle_end)
            begin
                stop_pend_r <= 1'b0;
                running_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Prescalers, counter and commands
    // Third flop only feeds the edge detector
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end
        else
        begin
            ext_s1_r <= ext_clock_pin;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    // Dividers hold while the selected source is silent
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cdiv_r <= 5'h00;
            sdiv_r <= 3'h0;
        end
        else if (timer_tick)
        begin
            cdiv_r <= cdiv_nxt;
            sdiv_r <= sdiv_nxt;
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            count_r <= '0;
        else if (!running_r || restart_go || cycle_end)
            count_r <= '0;
        else if (cnt_tick)
            count_r <= count_r + 12'h001;
    end

    // Commands wait for the sync tick; end-of-cycle load waits the cycle
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            cmd_pend_r <= 5'h00;
        else if (cmd_write_ok)
            cmd_pend_r <= wdata[4:0];
        else
        begin
            if (cmd_go_now)
                cmd_pend_r[4:1] <= 4'h0;
            if (eoc_done)
                cmd_pend_r[CS_SYNCEOC_BIT] <= 1'b0;
        end
    end

    // Capture runs on the tick that retires its strobe
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cap_a_r <= '0;
            cap_b_r <= '0;
        end
        else
        begin
            if (cap_a_go)
                cap_a_r <= count_r;
            if (cap_b_go)
                cap_b_r <= count_r;
        end
    end

    // ==========================================================
    // Waveforms and event strobes
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            evt_a_r <= 1'b0;
            evt_b_r <= 1'b0;
            evt_c_r <= 1'b0;
        end
        else
        begin
            evt_a_r <= hit_a;
            evt_b_r <= hit_b;
            evt_c_r <= cycle_end;
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            wave_a_r <= 1'b0;
        else if (!running_r || cycle_end)
            wave_a_r <= 1'b0;
        else if (hit_a)
            wave_a_r <= 1'b1;
        else if (clr_a)
            wave_a_r <= 1'b0;
    end

    // No clear match for B; only cycle end or a stopped timer (running_r low) drops it
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            wave_b_r <= 1'b0;
        else if (!running_r || cycle_end)
            wave_b_r <= 1'b0;
        else if (hit_b)
            wave_b_r <= 1'b1;
    end

    // ==========================================================
    // Interrupt flags: set beats the read that clears
    always_comb
    begin
        flags_nxt = flags_r;
        if (rd_flags)
            flags_nxt = 8'h00;
        if (cycle_end)
            flags_nxt[IF_CYCLE_BIT] = 1'b1;
        if (hit_a)
            flags_nxt[IF_ONA_BIT] = 1'b1;
        if (hit_b)
            flags_nxt[IF_ONB_BIT] = 1'b1;
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            flags_r <= 8'h00;
        else
            flags_r <= flags_nxt & IF_MASK;
    end

    // ==========================================================
    // Read path
    wire [7:0] main_rd =
        {1'b0, clk_sel_r, cpres_r, spres_r, mc_en_r};
    wire [7:0] status_rd =
        {wave_b_r, wave_a_r, 4'h0, cmd_pend_r == 5'h00, !en_busy};
    wire [7:0] rd_mux =
        !in_map ? 8'h00 :
        (addr == OFS_MAIN_CONTROL) ? main_rd :
        (addr == OFS_INTERRUPT_FLAGS) ? flags_r :
        (addr == OFS_TIMER_STATUS) ? status_rd :
        (addr == OFS_COMMAND_STROBES) ? 8'h00 :
        (addr == OFS_CAPTURE_A_VALUE) ? cap_a_r[7:0] :
        (addr == OFS_CAPTURE_A_VALUE + 1) ? {4'h0, cap_a_r[11:8]} :
        (addr == OFS_CAPTURE_B_VALUE) ? cap_b_r[7:0] :
        (addr == OFS_CAPTURE_B_VALUE + 1) ? {4'h0, cap_b_r[11:8]} :
        regs_q[addr];

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            rdata_r <= 8'h00;
        else if (rd_stb)
            rdata_r <= rd_mux;
        else
            rdata_r <= 8'h00;
    end

    // ==========================================================
    // Outputs
    assign rdata = rdata_r;
    assign wave_a = wave_a_r;
    assign wave_b = wave_b_r;
    assign match_a_set_evt = evt_a_r;
    assign match_b_set_evt = evt_b_r;
    assign match_b_clear_evt = evt_c_r;
    assign irq =
        |(flags_r & regs_q[OFS_INTERRUPT_ENABLES] & IF_MASK);
endmodule

// [design/wt_pkg.sv]
// Constants, register map and field layout of the waveform timer
package wt_pkg;
    // ==========================================================
    // Bus and register map
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int CNT_W = 12;
    localparam int MAP_SIZE = 48;
    localparam logic [5:0] OFS_MAIN_CONTROL = 6'h00;
    localparam logic [5:0] OFS_WAVEFORM_MODE_CONTROL = 6'h01;
    localparam logic [5:0] OFS_OUTPUT_ROUTING_CONTROL = 6'h02;
    localparam logic [5:0] OFS_OVERRIDE_VALUE_CONTROL = 6'h03;
    localparam logic [5:0] OFS_COMMAND_STROBES = 6'h04;
    localparam logic [5:0] OFS_EVENT_INPUT_A_CONTROL = 6'h08;
    localparam logic [5:0] OFS_EVENT_INPUT_B_CONTROL = 6'h09;
    localparam logic [5:0] OFS_INTERRUPT_ENABLES = 6'h0C;
    localparam logic [5:0] OFS_INTERRUPT_FLAGS = 6'h0D;
    localparam logic [5:0] OFS_TIMER_STATUS = 6'h0E;
    localparam logic [5:0] OFS_INPUT_A_MODE = 6'h10;
    localparam logic [5:0] OFS_INPUT_B_MODE = 6'h11;
    localparam logic [5:0] OFS_FAULT_OUTPUT_CONTROL = 6'h12;
    localparam logic [5:0] OFS_DELAY_CONTROL = 6'h14;
    localparam logic [5:0] OFS_DELAY_VALUE = 6'h15;
    localparam logic [5:0] OFS_DITHER_CONTROL = 6'h18;
    localparam logic [5:0] OFS_DITHER_VALUE = 6'h19;
    localparam logic [5:0] OFS_DEBUG_CONTROL = 6'h1E;
    localparam logic [5:0] OFS_CAPTURE_A_VALUE = 6'h22;
    localparam logic [5:0] OFS_CAPTURE_B_VALUE = 6'h24;
    localparam logic [5:0] OFS_COMPARE_A_SET = 6'h28;
    localparam logic [5:0] OFS_COMPARE_A_CLEAR = 6'h2A;
    localparam logic [5:0] OFS_COMPARE_B_SET = 6'h2C;
    localparam logic [5:0] OFS_COMPARE_B_CLEAR = 6'h2E;
    localparam logic [7:0] MAIN_CONTROL_RESET = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    // ==========================================================
    // Field positions
    localparam int MC_EN_BIT = 0;
    localparam int MC_SPRES_LSB = 1;
    localparam int MC_CPRES_LSB = 3;
    localparam int MC_CLOCK_SOURCE_SEL_LSB = 5;
    localparam int CS_SYNCEOC_BIT = 0;
    localparam int CS_SYNC_BIT = 1;
    localparam int CS_RESTART_BIT = 2;
    localparam int CS_CAPA_BIT = 3;
    localparam int CS_CAPB_BIT = 4;
    localparam int CS_STOP_BIT = 7;
    localparam int IF_CYCLE_BIT = 0;
    localparam int IF_ONA_BIT = 2;
    localparam int IF_ONB_BIT = 3;
    localparam int ST_ENDONE_BIT = 0;
    localparam int ST_CMDDONE_BIT = 1;
    localparam int ST_WAVEA_BIT = 6;
    localparam int ST_WAVEB_BIT = 7;
    localparam logic [7:0] IF_MASK = 8'h0D;
    localparam logic [7:0] HIGH_BYTE_MASK = 8'h0F;
    // ==========================================================
    // Codes
    localparam logic [1:0] CLK_FAST_OSC = 2'h0;
    localparam logic [1:0] CLK_EXTERNAL = 2'h2;
    localparam logic [1:0] CLK_SYSTEM = 2'h3;
    localparam logic [1:0] CPRES_DIV1 = 2'h0;
    localparam logic [1:0] CPRES_DIV4 = 2'h1;
    localparam logic [1:0] CPRES_DIV32 = 2'h2;
    localparam logic [4:0] DIV4_LAST = 5'h03;
    localparam logic [4:0] DIV32_LAST = 5'h1F;
    localparam logic [2:0] SYNC_DIV_LAST_1 = 3'h0;
    localparam logic [2:0] SYNC_DIV_LAST_2 = 3'h1;
    localparam logic [2:0] SYNC_DIV_LAST_4 = 3'h3;
    localparam logic [2:0] SYNC_DIV_LAST_8 = 3'h7;
    // Timer ticks taken by the enable crossing
    localparam logic [1:0] EN_SYNC_TICKS = 2'h2;

    // Writable bits of plain storage bytes, zero for special ones
    function automatic logic [7:0] wt_wmask(input int idx);
        logic [7:0] m;
        m = 8'h00;
        case (idx)
            1: m = 8'h03;
            2: m = 8'hCB;
            3: m = 8'hFF;
            8, 9: m = 8'hD5;
            12: m = 8'h0D;
            16, 17: m = 8'h0F;
            18: m = 8'hFF;
            20: m = 8'h3F;
            21: m = 8'hFF;
            24: m = 8'h03;
            25: m = 8'h0F;
            30: m = 8'h05;
            40, 42, 44, 46: m = 8'hFF;
            41, 43, 45, 47: m = HIGH_BYTE_MASK;
            default: m = 8'h00;
        endcase
        return m;
    endfunction
endpackage

// [verif/wt_timer_regs_properties.sv]
// Checker watching the waveform timer register block ports
module wt_timer_regs_properties
    import wt_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [DATA_W-1:0] rdata,
    // Waveforms, events and interrupt
    input wire logic wave_a,
    input wire logic wave_b,
    input wire logic match_a_set_evt,
    input wire logic match_b_set_evt,
    input wire logic match_b_clear_evt,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // Helper logic
    logic armed_r;
    logic armed_nxt;
    wire logic en_wr = wr_stb && addr == OFS_MAIN_CONTROL && wdata[MC_EN_BIT];
    wire logic quiet = !wave_a && !wave_b && !match_a_set_evt
        && !match_b_set_evt && !match_b_clear_evt;
    // Set by any enable attempt, so it never hides real activity
    assign armed_nxt = armed_r | en_wr;
    always_ff @(posedge clock or negedge rst_b)
        if (!rst_b)
            armed_r <= 1'b0;
        else
            armed_r <= armed_nxt;
    // ==========================================================
    // Properties
    sequence s_flag_read;
        rd_stb && addr == OFS_INTERRUPT_FLAGS;
    endsequence
    sequence s_first_enable;
        en_wr && !armed_r;
    endsequence
    property p_rdata_idle;
        !$past(rd_stb) |-> rdata == 8'h00;
    endproperty
    property p_high_byte;
        rd_stb && addr[5] && addr[0] |=> rdata[7:4] == 4'h0;
    endproperty
    property p_flags_spare;
        s_flag_read |=> (rdata & ~IF_MASK) == 8'h00;
    endproperty
    property p_flag_read_irq;
        s_flag_read ##1 rdata == 8'h00 |-> !$past(irq);
    endproperty
    property p_irq_hold;
        irq && !(rd_stb && addr == OFS_INTERRUPT_FLAGS)
            && !(wr_stb && addr == OFS_INTERRUPT_ENABLES) |=> irq;
    endproperty
    property p_irq_mask;
        wr_stb && addr == OFS_INTERRUPT_ENABLES && wdata == 8'h00 |=> !irq;
    endproperty
    property p_idle_quiet;
        !armed_r |-> quiet;
    endproperty
    property p_en_latency;
        s_first_enable |=> quiet [*2];
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside read slot");
    a_high_byte: assert property (p_high_byte)
        else $error("high byte upper bits not zero");
    a_flags_spare: assert property (p_flags_spare)
        else $error("unused flag bits set");
    a_flag_read_irq: assert property (p_flag_read_irq)
        else $error("interrupt high with no flag set");
    a_irq_hold: assert property (p_irq_hold)
        else $error("interrupt dropped without clear or mask");
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt high after masking all");
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("timer activity before any enable");
    a_en_latency: assert property (p_en_latency)
        else $error("timer active before enable crossing");
endmodule

bind wt_timer_regs wt_timer_regs_properties u_wt_timer_regs_properties (
    .clock(clock),
    .rst_b(rst_b),
    .addr(addr),
    .wdata(wdata),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .rdata(rdata),
    .wave_a(wave_a),
    .wave_b(wave_b),
    .match_a_set_evt(match_a_set_evt),
    .match_b_set_evt(match_b_set_evt),
    .match_b_clear_evt(match_b_clear_evt),
    .irq(irq)
);

// [verif/test_wt_timer_regs.sv]
// Self-checking bench for the waveform timer register block
module test_wt_timer_regs
    import wt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic fast_osc_tick = 1'b0;
    logic ext_clock_pin = 1'b0;
    logic [2:0] ph = 3'h0;
    logic [ADDR_W-1:0] addr = 6'h00;
    logic [DATA_W-1:0] wdata = 8'h00;
    logic [DATA_W-1:0] rdata;
    logic wave_a, wave_b, match_a_set_evt, match_b_set_evt;
    logic match_b_clear_evt, irq;
    logic [7:0] v;
    int fails = 0;
    int num_checks = 0;
    int n;
    logic [5:0] wa, wb, ea, eb;
    logic [1:0] codes [3] = '{CLK_FAST_OSC, CLK_EXTERNAL, CLK_SYSTEM};
    logic [1:0] src [5] = '{2'h3, 2'h3, 2'h3, 2'h2, 2'h0};
    logic [1:0] pre [5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0};
    int len [5] = '{4, 16, 128, 32, 8};

    initial
    begin
        forever #20 clock = ~clock;
    end
    // Tick every second cycle, pin period of eight cycles
    always @(posedge clock)
    begin
        fast_osc_tick <= ~fast_osc_tick;
        ph <= ph + 3'h1;
        ext_clock_pin <= ph[2];
    end

    wt_timer_regs u_wt_timer_regs (
        .clock(clock),
        .rst_b(rst_b),
        .addr(addr),
        .wdata(wdata),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .rdata(rdata),
        .fast_osc_tick(fast_osc_tick),
        .ext_clock_pin(ext_clock_pin),
        .wave_a(wave_a),
        .wave_b(wave_b),
        .match_a_set_evt(match_a_set_evt),
        .match_b_set_evt(match_b_set_evt),
        .match_b_clear_evt(match_b_clear_evt),
        .irq(irq)
    );
    // ==========================================================
    // Tasks
    task automatic chk(input string nm, input logic [15:0] s, e);
        num_checks++;
        if (s !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Hold keeps the strobe up for a back-to-back write
    task automatic wr(input logic [5:0] a, logic [7:0] d, bit hold = 0);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        rd_stb <= 1'b0;
        @(posedge clock);
        if (!hold)
        begin
            wr_stb <= 1'b0;
            @(posedge clock);
        end
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        addr <= a;
        rd_stb <= 1'b1;
        wr_stb <= 1'b0;
        @(posedge clock);
        rd_stb <= 1'b0;
        @(negedge clock);
        d = rdata;
        @(posedge clock);
    endtask
    task automatic rc(input string nm, logic [5:0] a, logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(nm, d, e);
    endtask
    task automatic wait_ready();
        logic [7:0] d;
        int t;
        t = 0;
        do
        begin
            rd(OFS_TIMER_STATUS, d);
            t++;
        end
        while (d[ST_ENDONE_BIT] !== 1'b1 && t < 300);
        chk("enable ready", d[ST_ENDONE_BIT], 1'b1);
    endtask
    // Cycles between two cycle-end pulses
    task automatic period_of(output int c);
        c = 0;
        @(negedge clock);
        while (match_b_clear_evt !== 1'b1 && c < 2000)
        begin
            @(negedge clock);
            c++;
        end
        c = 0;
        do
        begin
            @(negedge clock);
            c++;
        end
        while (match_b_clear_evt === 1'b1 && c < 50);
        while (match_b_clear_evt !== 1'b1 && c < 2000)
        begin
            @(negedge clock);
            c++;
        end
        @(posedge clock);
    endtask
    task automatic chk_irq(input logic e);
        @(negedge clock);
        chk("irq", irq, e);
        @(posedge clock);
    endtask
    // Output levels for six cycles from a cycle end, bit k at cycle k
    task automatic wave_walk(output logic [5:0] lv_a, lv_b, ev_a, ev_b);
        int t;
        t = 0;
        @(negedge clock);
        while (match_b_clear_evt !== 1'b1 && t < 2000)
        begin
            @(negedge clock);
            t++;
        end
        for (int k = 0; k < 6; k++)
        begin
            lv_a[k] = wave_a;
            lv_b[k] = wave_b;
            ev_a[k] = match_a_set_evt;
            ev_b[k] = match_b_set_evt;
            @(negedge clock);
        end
        @(posedge clock);
    endtask
    task automatic end_sim();
        $display("Checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial
    begin
        repeat (20000) @(posedge clock);
        fails++;
        $display("Error watchdog expected finish seen hang");
        end_sim();
    end
    initial
    begin
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        rc("main_control", OFS_MAIN_CONTROL, 8'h00);
        rc("flags", OFS_INTERRUPT_FLAGS, 8'h00);
        rc("reserved", 6'h05, 8'h00);
        rc("unmapped", 6'h3F, 8'h00);
        foreach (codes[i])
            for (int c = 0; c < 3; c++)
                for (int s = 0; s < 4; s++)
                begin
                    v = {1'b0, codes[i], c[1:0], s[1:0], 1'b0};
                    wr(OFS_MAIN_CONTROL, v);
                    rc("fields", OFS_MAIN_CONTROL, v);
                end
        wr(OFS_COMPARE_A_SET + 6'h01, 8'hFF);
        rc("cmp high", OFS_COMPARE_A_SET + 6'h01, 8'h0F);
        wr(OFS_COMPARE_A_SET, 8'hA5);
        rc("cmp low", OFS_COMPARE_A_SET, 8'hA5);
        $display("Test fields done");
        wr(OFS_COMPARE_B_CLEAR, 8'h03);
        wr(OFS_COMPARE_B_CLEAR + 6'h01, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            wr(OFS_MAIN_CONTROL, {1'b0, src[i], pre[i], 3'h1});
            period_of(n);
            chk("cycle length", n[15:0], len[i][15:0]);
            wr(OFS_COMMAND_STROBES, 8'h80);
            rd(OFS_TIMER_STATUS, v);
            if (i == 2)
                chk("stop pending", v[ST_ENDONE_BIT], 1'b0);
            wait_ready();
            rc("stopped", OFS_MAIN_CONTROL, {1'b0, src[i], pre[i], 3'h0});
        end
        $display("Test clocking done");
        wr(OFS_MAIN_CONTROL, 8'h61);
        wait_ready();
        wr(OFS_MAIN_CONTROL, 8'h67);
        rc("protected", OFS_MAIN_CONTROL, 8'h61);
        wr(OFS_MAIN_CONTROL, 8'h60, 1'b1);
        wr(OFS_MAIN_CONTROL, 8'h61);
        wait_ready();
        rc("enable refused", OFS_MAIN_CONTROL, 8'h60);
        $display("Test enable done");
        wr(OFS_COMPARE_A_SET, 8'h01);
        wr(OFS_COMPARE_A_SET + 6'h01, 8'h00);
        wr(OFS_COMPARE_A_CLEAR, 8'h03);
        wr(OFS_COMPARE_B_SET, 8'h02);
        wr(OFS_COMPARE_B_CLEAR, 8'h05);
        wr(OFS_MAIN_CONTROL, 8'h61);
        wave_walk(wa, wb, ea, eb);
        chk("wave_a", wa, 6'h0C);
        chk("wave_b", wb, 6'h38);
        chk("match_a_set_evt", ea, 6'h04);
        chk("match_b_set_evt", eb, 6'h08);
        wr(OFS_COMMAND_STROBES, 8'h80);
        wait_ready();
        rc("flags set", OFS_INTERRUPT_FLAGS, 8'h0D);
        $display("Test waveform done");
        wr(OFS_INTERRUPT_ENABLES, 8'h01);
        chk_irq(1'b0);
        wr(OFS_MAIN_CONTROL, 8'h71);
        period_of(n);
        chk_irq(1'b1);
        wr(OFS_INTERRUPT_ENABLES, 8'h00);
        chk_irq(1'b0);
        wr(OFS_INTERRUPT_ENABLES, 8'h01);
        chk_irq(1'b1);
        wr(OFS_COMMAND_STROBES, 8'h80);
        wait_ready();
        rd(OFS_INTERRUPT_FLAGS, v);
        chk("cycle flag", v[IF_CYCLE_BIT], 1'b1);
        chk("flag spare", v & ~IF_MASK, 8'h00);
        chk("event flags", v, 8'h0D);
        chk_irq(1'b0);
        rc("flags cleared", OFS_INTERRUPT_FLAGS, 8'h00);
        $display("Test interrupt done");
        end_sim();
    end
endmodule
